/* include/mps_pkg.sv */
// Shared constants and types for the microprogram sequencer
package mps_pkg;

   // Address and field widths
   localparam int ADDR_W = 14;
   localparam int WORD_W = 16;
   localparam int SUCC_W = 3;
   localparam int CTRL_W = 4;
   localparam int SECTION_W = 4;

   // Control bit positions in the microword (bit 15 is the first control bit)
   localparam int CTRL_HI = 15;
   localparam int CTRL_LO = 12;

   // Values after reset
   localparam logic [13:0] ADDR_RST = 14'h0000;
   localparam logic [2:0] SUCC_RST = 3'h1;

   // Microword control codes
   localparam logic [3:0] CTRL_SHORT = 4'hf;
   localparam logic [1:0] CTRL2_LOAD_ALT = 2'h0;
   localparam logic [1:0] CTRL2_JUMP = 2'h1;
   localparam logic [1:0] CTRL2_CALL = 2'h2;
   localparam logic [3:0] CTRL4_CONST_SHIFT = 4'hc;
   localparam logic [3:0] CTRL4_CONST = 4'he;

   // Successor codes in the order of their encodings 0 to 7
   typedef enum logic [2:0] {
      MPS_WAIT,
      MPS_STEP,
      MPS_SAVE,
      MPS_SKIP,
      MPS_RUN_SINGLE_REMOTE,
      MPS_JUMP,
      MPS_CALL,
      MPS_SUBROUTINE_BACK
   } mps_succ_e;

   // Source for the next-address select gates
   typedef enum logic [1:0] {
      MPS_SRC_COUNTER,
      MPS_SRC_ALTERNATE,
      MPS_SRC_MICROWORD
   } mps_src_e;

   // Pending barrel-shifter store of the alternate register
   typedef enum logic [1:0] {
      MPS_BS_IDLE,
      MPS_BS_PENDING,
      MPS_BS_ARMED
   } mps_bs_e;

endpackage

/* rtl/mps_incrementer.sv */
// Plus-one and plus-two adder built from chained 4-bit sections
`timescale 1ns/1ps
`default_nettype none
module mps_incrementer
   import mps_pkg::*;
#(
   parameter int WIDTH = ADDR_W
) (
   // Operand
   input wire logic [WIDTH-1:0] operand,
   // Sums
   output logic [WIDTH-1:0] plus_one,
   output logic [WIDTH-1:0] plus_two
);

   localparam int NSEC = (WIDTH + SECTION_W - 1) / SECTION_W;

   // Carry between sections for each of the two adders
   logic [NSEC:0] carry_one;
   logic [NSEC:0] carry_two;

   assign carry_one[0] = 1'b0;
   assign carry_two[0] = 1'b0;

   // Each section adds its share of the increment plus the incoming carry
   for (genvar s = 0; s < NSEC; s++) begin : g_sec
      localparam int LO = s * SECTION_W;
      localparam int HI = (LO + SECTION_W > WIDTH) ? WIDTH - 1 : LO + SECTION_W - 1;
      localparam int W = HI - LO + 1;
      logic [W:0] sum_one;
      logic [W:0] sum_two;
      logic [W-1:0] add_one;
      logic [W-1:0] add_two;
      assign add_one = (s == 0) ? W'(1) : W'(0);
      assign add_two = (s == 0) ? W'(2) : W'(0);
      assign sum_one = {1'b0, operand[HI:LO]} + {1'b0, add_one} + (W+1)'(carry_one[s]); // [RQ6]
      assign sum_two = {1'b0, operand[HI:LO]} + {1'b0, add_two} + (W+1)'(carry_two[s]); // [RQ6]
      assign plus_one[HI:LO] = sum_one[W-1:0];
      assign plus_two[HI:LO] = sum_two[W-1:0];
      assign carry_one[s+1] = sum_one[W]; // [RQ6]
      assign carry_two[s+1] = sum_two[W]; // [RQ6]
   end

endmodule // mps_incrementer
`default_nettype wire

/* rtl/mps_sequencer.sv */
// Microprogram address sequencer: counter, alternate and next-address registers
// What this block does
// [RQ1] Barrel store delayed to next short-word phase 3
// [RQ2] Alternate value readable within its own microinstruction
// [RQ3] Next-address register holds selected source plus 1/2
// [RQ4] Four select controls pick the incremented source
// [RQ5] Next-address register loads on clock with strobe
// [RQ6] Adders are chained 4-bit sections with carries
// [RQ7] Registered address to memory, gates to counter
// [RQ8] Condition picks true or false successor code
// [RQ9] Counter update per successor code table
// [RQ10] Counter saved to alternate on SAVE, CALL
// [RQ11] Remote fetch takes alternate plus one, counter held
// [RQ12] WAIT leaves all three registers unchanged
// [RQ13] Next-address strobe on nonzero code, not hold
// [RQ14] Hold freezes counter and next-address register
// [RQ15] Long jump/call loads microword field plus one
// [RQ16] Phase 3 blocked for long words, failed conditions
// [RQ17] Condition logic supplies condition failed indication
// [RQ18] Alternate loads from microword on control 00
// [RQ19] Constant register load on control 1110, 1100
// [RQ20] Conditional bit makes phase 3 depend on condition
// [RQ21] Successor controls latched at start of phase 1
// [RQ22] Reset clears all three address registers
`timescale 1ns/1ps
`default_nettype none
module mps_sequencer
   import mps_pkg::*;
#(
   parameter int AW = ADDR_W
) (
   // Clock, reset, enable
   input wire logic clock,
   input wire logic sys_rst,
   input wire logic clk_en,
   // Phase timing
   input wire logic phase1_start,
   input wire logic gated_system_clock,
   input wire logic phase3_clock,
   // Microword and nanobits
   input wire logic [WORD_W-1:0] microcode_store,
   input wire logic [SUCC_W-1:0] true_successor_field,
   input wire logic [SUCC_W-1:0] false_successor_field,
   input wire logic phase3_conditional_bit,
   input wire logic forced_long_format,
   // Condition logic and memory control
   input wire logic condition_met,
   input wire logic condition_failed,
   input wire logic sequencer_hold,
   // Barrel shifter path into the alternate register
   input wire logic barrel_load_req,
   input wire logic [AW-1:0] barrel_shifter,
   // Addresses
   output logic [AW-1:0] micro_address,
   output logic [AW-1:0] micro_program_counter,
   output logic [AW-1:0] alternate_address_reg,
   // Decoded controls
   output logic counter_plus_one_sel,
   output logic counter_plus_two_sel,
   output logic alternate_plus_one_sel,
   output logic alternate_plus_two_sel,
   output logic program_counter_strobe,
   output logic next_address_strobe,
   output logic save_pc_to_alternate,
   output logic load_alternate_from_microword,
   output logic long_format_word,
   output logic long_branch_select,
   output logic direct_subroutine_entry,
   output logic constant_value_load,
   output logic phase3_clock_block
);

   // Latched sequencer controls
   logic [SUCC_W-1:0] succ_q, succ_d;
   logic cp1_q, cp1_d;
   logic cp2_q, cp2_d;
   logic ap1_q, ap1_d;
   logic ap2_q, ap2_d;
   logic pcs_q, pcs_d;
   logic nas_q, nas_d;
   logic save_q, save_d;
   logic lam_q, lam_d;
   logic long_q, long_d;
   logic lbs_q, lbs_d;
   logic dse_q, dse_d;
   logic cvl_q, cvl_d;
   logic block_q, block_d;
   logic [AW-1:0] field_q, field_d;

   // Address registers
   logic [AW-1:0] pc_q, pc_d;
   logic [AW-1:0] alt_q, alt_d;
   logic [AW-1:0] nar_q, nar_d;

   // Barrel store sequencing
   mps_bs_e bs_q, bs_d;
   logic [AW-1:0] bs_data_q, bs_data_d;

   // Adder outputs and select gates
   logic [AW-1:0] src_m;
   logic [AW-1:0] m_plus1, m_plus2;
   logic [AW-1:0] a_plus1, a_plus2;
   logic [AW-1:0] select_gates;

   // Decode of the current microword
   logic [CTRL_W-1:0] ctrl;
   logic [SUCC_W-1:0] succ_sel;
   logic is_long, is_branch, is_direct_subroutine_entry;
   logic step_edge;

   assign ctrl = microcode_store[CTRL_HI:CTRL_LO];

   // Counter or microword field feeds the M adders
   assign src_m = lbs_q ? field_q : pc_q; // [RQ15]

   mps_incrementer #(
      .WIDTH(AW)
   ) u_m_add (
      .operand(src_m),
      .plus_one(m_plus1),
      .plus_two(m_plus2)
   );

   mps_incrementer #(
      .WIDTH(AW)
   ) u_a_add (
      .operand(alt_q),
      .plus_one(a_plus1),
      .plus_two(a_plus2)
   );

   // AND-OR select gates; only one select is high at a time
   assign select_gates = ({AW{cp1_q}} & m_plus1) | ({AW{cp2_q}} & m_plus2) | // [RQ4]
      ({AW{ap1_q}} & a_plus1) | ({AW{ap2_q}} & a_plus2); // [RQ4]

   // Control decode, latched at the start of phase 1
   always_comb begin
      succ_sel = condition_met ? true_successor_field : false_successor_field; // [RQ8]
      is_long = (ctrl != CTRL_SHORT) || forced_long_format;
      is_branch = !forced_long_format && ((ctrl[3:2] == CTRL2_JUMP) ||
         (ctrl[3:2] == CTRL2_CALL));
      is_direct_subroutine_entry = !forced_long_format && (ctrl[3:2] == CTRL2_CALL);
      succ_d = succ_q;
      cp1_d = cp1_q;
      cp2_d = cp2_q;
      ap1_d = ap1_q;
      ap2_d = ap2_q;
      pcs_d = pcs_q;
      nas_d = nas_q;
      save_d = save_q;
      lam_d = lam_q;
      long_d = long_q;
      lbs_d = lbs_q;
      dse_d = dse_q;
      cvl_d = cvl_q;
      block_d = block_q;
      field_d = field_q;
      if (phase1_start) begin
         succ_d = succ_sel; // [RQ21]
         field_d = microcode_store[AW-1:0];
         long_d = is_long;
         lbs_d = is_long && is_branch; // [RQ15]
         dse_d = is_long && is_direct_subroutine_entry; // [RQ15]
         lam_d = is_long && !forced_long_format && (ctrl[3:2] == CTRL2_LOAD_ALT); // [RQ18]
         cvl_d = (ctrl == CTRL4_CONST) || (ctrl == CTRL4_CONST_SHIFT); // [RQ19]
         // Phase 3 runs unless long format, or the condition failed and it was conditional
         block_d = is_long || (condition_failed && phase3_conditional_bit); // [RQ16] [RQ20]
         cp1_d = 1'b0;
         cp2_d = 1'b0;
         ap1_d = 1'b0;
         ap2_d = 1'b0;
         if (is_long) begin
            // Long words ignore the successor and always select plus one of the counter or the microword field
            cp1_d = 1'b1; // [RQ15]
            pcs_d = !sequencer_hold; // [RQ14]
            nas_d = !sequencer_hold; // [RQ14]
            save_d = is_long && is_direct_subroutine_entry; // [RQ10]
         end else begin
            unique case (mps_succ_e'(succ_sel))
               MPS_WAIT: begin
                  cp1_d = 1'b0; // [RQ12]
               end
               MPS_STEP, MPS_SAVE: begin
                  cp1_d = 1'b1; // [RQ9]
               end
               MPS_SKIP: begin
                  cp2_d = 1'b1; // [RQ9]
               end
               MPS_RUN_SINGLE_REMOTE, MPS_JUMP, MPS_CALL: begin
                  ap1_d = 1'b1; // [RQ9] [RQ11]
               end
               MPS_SUBROUTINE_BACK: begin
                  ap2_d = 1'b1; // [RQ9]
               end
            endcase
            // Counter is not strobed for WAIT or a remote fetch
            pcs_d = (succ_sel != SUCC_W'(MPS_WAIT)) &&
               (succ_sel != SUCC_W'(MPS_RUN_SINGLE_REMOTE)) && !sequencer_hold; // [RQ11] [RQ12]
            nas_d = (succ_sel != SUCC_W'(MPS_WAIT)) && !sequencer_hold; // [RQ13] [RQ14]
            save_d = (succ_sel == SUCC_W'(MPS_SAVE)) ||
               (succ_sel == SUCC_W'(MPS_CALL)); // [RQ10]
         end
      end
   end

   // Address register update on the gated system clock, barrel store into the alternate register on phase 3
   always_comb begin
      step_edge = gated_system_clock && !phase1_start;
      pc_d = pc_q;
      alt_d = alt_q;
      nar_d = nar_q;
      bs_d = bs_q;
      bs_data_d = bs_data_q;
      // Hold is also checked live so a late hold still freezes the counter and next-address register
      if (step_edge && !sequencer_hold) begin // [RQ14]
         if (nas_q) begin
            nar_d = select_gates; // [RQ3] [RQ5]
         end
         if (pcs_q) begin
            pc_d = select_gates; // [RQ7] [RQ9]
         end
      end
      if (step_edge) begin
         if (save_q) begin
            alt_d = pc_q; // [RQ10]
         end else if (lam_q) begin
            alt_d = field_q; // [RQ18]
         end
      end
      // Barrel store waits for the phase 3 of the next short-format word
      unique case (bs_q)
         MPS_BS_IDLE: begin
            bs_d = MPS_BS_IDLE;
         end
         MPS_BS_PENDING: begin
            if (phase1_start && (ctrl == CTRL_SHORT) && !forced_long_format) begin
               bs_d = MPS_BS_ARMED; // [RQ1]
            end
         end
         MPS_BS_ARMED: begin
            if (phase1_start) begin
               // Missed store: a following short word takes it over at once
               bs_d = ((ctrl == CTRL_SHORT) && !forced_long_format) ? MPS_BS_ARMED :
                  MPS_BS_PENDING; // [RQ1]
            end else if (phase3_clock && !block_q) begin
               alt_d = bs_data_q; // [RQ1]
               bs_d = MPS_BS_IDLE;
            end
         end
         default: begin
            bs_d = MPS_BS_IDLE;
         end
      endcase
      // A new request overrides any earlier one still waiting
      if (phase3_clock && barrel_load_req && !block_q) begin
         bs_data_d = barrel_shifter;
         bs_d = MPS_BS_PENDING; // [RQ1]
      end
   end

   // Control registers
   always_ff @(posedge clock) begin
      if (sys_rst) begin
         succ_q <= SUCC_RST;
         cp1_q <= 1'b0;
         cp2_q <= 1'b0;
         ap1_q <= 1'b0;
         ap2_q <= 1'b0;
         pcs_q <= 1'b0;
         nas_q <= 1'b0;
         save_q <= 1'b0;
         lam_q <= 1'b0;
         long_q <= 1'b0;
         lbs_q <= 1'b0;
         dse_q <= 1'b0;
         cvl_q <= 1'b0;
         block_q <= 1'b0;
         field_q <= ADDR_RST;
      end else if (clk_en) begin
         succ_q <= succ_d;
         cp1_q <= cp1_d;
         cp2_q <= cp2_d;
         ap1_q <= ap1_d;
         ap2_q <= ap2_d;
         pcs_q <= pcs_d;
         nas_q <= nas_d;
         save_q <= save_d;
         lam_q <= lam_d;
         long_q <= long_d;
         lbs_q <= lbs_d;
         dse_q <= dse_d;
         cvl_q <= cvl_d;
         block_q <= block_d;
         field_q <= field_d;
      end
   end

   // Address and barrel registers
   always_ff @(posedge clock) begin
      if (sys_rst) begin
         pc_q <= ADDR_RST; // [RQ22]
         alt_q <= ADDR_RST; // [RQ22]
         nar_q <= ADDR_RST; // [RQ22]
         bs_q <= MPS_BS_IDLE;
         bs_data_q <= ADDR_RST;
      end else if (clk_en) begin
         pc_q <= pc_d;
         alt_q <= alt_d;
         nar_q <= nar_d;
         bs_q <= bs_d;
         bs_data_q <= bs_data_d;
      end
   end

   // Outputs straight from flip-flops
   assign micro_address = nar_q; // [RQ7]
   assign micro_program_counter = pc_q;
   assign alternate_address_reg = alt_q; // [RQ2]
   assign counter_plus_one_sel = cp1_q;
   assign counter_plus_two_sel = cp2_q;
   assign alternate_plus_one_sel = ap1_q;
   assign alternate_plus_two_sel = ap2_q;
   assign program_counter_strobe = pcs_q;
   assign next_address_strobe = nas_q;
   assign save_pc_to_alternate = save_q;
   assign load_alternate_from_microword = lam_q;
   assign long_format_word = long_q;
   assign long_branch_select = lbs_q;
   assign direct_subroutine_entry = dse_q;
   assign constant_value_load = cvl_q;
   assign phase3_clock_block = block_q; // [RQ16]

endmodule // mps_sequencer
`default_nettype wire

/* sim/mps_sequencer_chk.sv */
// Concurrent checks on the sequencer ports
`timescale 1ns/1ps
`default_nettype none
module mps_sequencer_chk
   import mps_pkg::*;
#(
   parameter int AW = ADDR_W
) (
   // Clock, reset, enable
   input wire logic clock,
   input wire logic sys_rst,
   input wire logic clk_en,
   // Phase timing
   input wire logic phase1_start,
   input wire logic gated_system_clock,
   // Microword, nanobits, condition, hold
   input wire logic [WORD_W-1:0] microcode_store,
   input wire logic [SUCC_W-1:0] true_successor_field,
   input wire logic [SUCC_W-1:0] false_successor_field,
   input wire logic phase3_conditional_bit,
   input wire logic forced_long_format,
   input wire logic condition_met,
   input wire logic condition_failed,
   input wire logic sequencer_hold,
   // Observed outputs
   input wire logic [AW-1:0] micro_address,
   input wire logic [AW-1:0] micro_program_counter,
   input wire logic [AW-1:0] alternate_address_reg,
   input wire logic counter_plus_one_sel,
   input wire logic alternate_plus_one_sel,
   input wire logic program_counter_strobe,
   input wire logic next_address_strobe,
   input wire logic save_pc_to_alternate,
   input wire logic long_branch_select,
   input wire logic phase3_clock_block
);
   logic [2:0] code;
   logic lng;
   logic blk_in;
   logic p1;
   logic gs;
   assign code = condition_met ? true_successor_field : false_successor_field;
   assign lng = (microcode_store[15:12] != 4'hf) || forced_long_format;
   assign blk_in = lng || (condition_failed && phase3_conditional_bit);
   assign p1 = phase1_start && clk_en;
   // A gated pulse coinciding with phase 1 start is ignored
   assign gs = gated_system_clock && clk_en && !phase1_start;
   default clocking @(posedge clock); endclocking
   default disable iff (sys_rst);
   wait_quiet_a: assert property (p1 && !lng && code == 3'h0 |=>
      !program_counter_strobe && !next_address_strobe) else $error("wait gave a strobe");
   strobe_code_a: assert property (p1 && !lng && !sequencer_hold && code != 3'h0 |=>
      next_address_strobe) else $error("next-address strobe missing");
   hold_strobe_a: assert property (p1 && sequencer_hold |=>
      !program_counter_strobe && !next_address_strobe) else $error("strobe under hold");
   remote_sel_a: assert property (p1 && !lng && code == 3'h4 |=>
      alternate_plus_one_sel && !program_counter_strobe) else $error("remote fetch controls");
   hold_freeze_a: assert property (gs && sequencer_hold |=>
      $stable(micro_address) && $stable(micro_program_counter)) else $error("hold not frozen");
   addr_quiet_a: assert property (!(gs && next_address_strobe) |=>
      $stable(micro_address)) else $error("address moved unstrobed");
   step_addr_a: assert property (gs && !sequencer_hold && counter_plus_one_sel &&
      !long_branch_select && next_address_strobe && program_counter_strobe |=>
      micro_address == AW'($past(micro_program_counter) + 1'b1) &&
      micro_program_counter == micro_address) else $error("step address wrong");
   long_jump_a: assert property (gs && long_branch_select && next_address_strobe &&
      !sequencer_hold |=> micro_address == AW'($past(microcode_store[13:0]) + 1'b1))
      else $error("long branch address wrong");
   save_alt_a: assert property (gs && save_pc_to_alternate |=>
      alternate_address_reg == $past(micro_program_counter)) else $error("save wrong");
   phase3_block_a: assert property (p1 |=> phase3_clock_block == $past(blk_in))
      else $error("phase 3 block wrong");
endmodule // mps_sequencer_chk
bind mps_sequencer mps_sequencer_chk #(.AW(AW)) u_chk (.clock, .sys_rst, .clk_en,
   .phase1_start, .gated_system_clock, .microcode_store, .true_successor_field,
   .false_successor_field, .phase3_conditional_bit, .forced_long_format, .condition_met,
   .condition_failed, .sequencer_hold, .micro_address, .micro_program_counter,
   .alternate_address_reg, .counter_plus_one_sel, .alternate_plus_one_sel,
   .program_counter_strobe, .next_address_strobe, .save_pc_to_alternate,
   .long_branch_select, .phase3_clock_block);
`default_nettype wire

/* sim/mps_far_model.sv */
// Far side: microword store output and condition logic
`timescale 1ns/1ps
`default_nettype none
module mps_far_model (
   // Word presented at the current address, condition outcome
   input wire logic [15:0] word_in,
   input wire logic met,
   // To the sequencer
   output logic [15:0] microcode_store,
   output logic condition_failed
);
   assign microcode_store = word_in;
   // Complement of the condition, never independent of it
   assign condition_failed = ~met;
endmodule // mps_far_model
`default_nettype wire

/* sim/mps_sequencer_test.sv */
// Sequencer testbench: instruction-level stimulus with a reference model
`timescale 1ns/1ps
`default_nettype none
module mps_sequencer_test;
   import mps_pkg::*;
   logic clock, sys_rst, clk_en, phase1_start, gated_system_clock, phase3_clock;
   logic forced_long_format, condition_met, condition_failed, sequencer_hold;
   logic barrel_load_req, phase3_conditional_bit, program_counter_strobe;
   logic next_address_strobe, constant_value_load, phase3_clock_block, pend;
   logic counter_plus_two_sel, alternate_plus_two_sel, long_format_word;
   logic load_alternate_from_microword, direct_subroutine_entry;
   logic [15:0] word, microcode_store;
   logic [2:0] tf, ff;
   logic [13:0] barrel_shifter, micro_address, micro_program_counter, alternate_address_reg;
   logic [13:0] exp_pc, exp_alt, exp_na, bar_val;
   int err_total, samples_checked, cycle_count;
   mps_far_model far (.word_in(word), .met(condition_met), .microcode_store,
      .condition_failed);
   mps_sequencer dut (.clock, .sys_rst, .clk_en, .phase1_start, .gated_system_clock,
      .phase3_clock, .microcode_store, .true_successor_field(tf), .false_successor_field(ff),
      .phase3_conditional_bit, .forced_long_format, .condition_met, .condition_failed,
      .sequencer_hold, .barrel_load_req, .barrel_shifter, .micro_address,
      .micro_program_counter, .alternate_address_reg, .counter_plus_one_sel(),
      .counter_plus_two_sel, .alternate_plus_one_sel(), .alternate_plus_two_sel,
      .program_counter_strobe, .next_address_strobe, .save_pc_to_alternate(),
      .load_alternate_from_microword, .long_format_word, .long_branch_select(),
      .direct_subroutine_entry, .constant_value_load, .phase3_clock_block);
   always #20 clock = ~clock;
   task chk(input logic [13:0] s, input logic [13:0] e);
      samples_checked++;
      if (s !== e) begin
         err_total++;
         $display("Error t=%0t seen=%h exp=%h", $time, s, e);
      end
   endtask
   task summarize;
      if (err_total == 0 && samples_checked > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   // One microinstruction: phase 1 start, gated clock, phase 3, then compare
   task automatic run(input logic [15:0] w, input logic fl, input logic [2:0] code,
      input logic c, input logic cnd, input logic hold, input logic bl);
      logic lng, blk;
      logic [13:0] t;
      lng = w[15:12] != 4'hf || fl;
      blk = lng || (!c && cnd);
      @(posedge clock);
      #1;
      word = w;
      forced_long_format = fl;
      tf = c ? code : ~code;
      ff = c ? ~code : code;
      condition_met = c;
      phase3_conditional_bit = cnd;
      sequencer_hold = hold;
      barrel_shifter = w[13:0];
      phase1_start = 1'b1;
      @(posedge clock);
      #1;
      phase1_start = 1'b0;
      gated_system_clock = 1'b1;
      chk(14'(phase3_clock_block), 14'(blk));
      chk(14'(next_address_strobe), 14'(!hold && (lng || code != 3'h0)));
      chk(14'(program_counter_strobe), 14'(!hold && (lng || !(code inside {0, 4}))));
      chk(14'(constant_value_load), 14'(w[15:12] == 4'hc || w[15:12] == 4'he));
      chk(14'(counter_plus_two_sel), 14'(!lng && code == 3'h3));
      chk(14'(alternate_plus_two_sel), 14'(!lng && code == 3'h7));
      chk(14'(long_format_word), 14'(lng));
      chk(14'(load_alternate_from_microword), 14'(lng && !fl && w[15:14] == 2'h0));
      chk(14'(direct_subroutine_entry), 14'(lng && !fl && w[15:14] == 2'h2));
      @(posedge clock);
      #1;
      gated_system_clock = 1'b0;
      phase3_clock = 1'b1;
      barrel_load_req = bl;
      @(posedge clock);
      #1;
      phase3_clock = 1'b0;
      barrel_load_req = 1'b0;
      if (!hold && lng) begin
         if (fl || w[15:14] == 2'h3) exp_pc = exp_pc + 14'h1;
         else begin
            if (w[15:14] == 2'h0) exp_alt = w[13:0];
            if (w[15:14] == 2'h2) exp_alt = exp_pc;
            exp_pc = (w[15:14] == 2'h0) ? exp_pc + 14'h1 : w[13:0] + 14'h1;
         end
         exp_na = exp_pc;
      end else if (!hold) begin
         case (code)
            3'h1: exp_pc = exp_pc + 14'h1;
            3'h2: begin
               exp_alt = exp_pc;
               exp_pc = exp_pc + 14'h1;
            end
            3'h3: exp_pc = exp_pc + 14'h2;
            3'h5: exp_pc = exp_alt + 14'h1;
            3'h6: begin
               t = exp_alt + 14'h1;
               exp_alt = exp_pc;
               exp_pc = t;
            end
            3'h7: exp_pc = exp_alt + 14'h2;
            default: ;
         endcase
         if (code != 3'h0) exp_na = (code == 3'h4) ? exp_alt + 14'h1 : exp_pc;
      end
      // Store lands only at the next unblocked short word
      if (pend && !lng && !blk) begin
         exp_alt = bar_val;
         pend = 1'b0;
      end
      if (bl && !blk) begin
         pend = 1'b1;
         bar_val = w[13:0];
      end
      chk(micro_program_counter, exp_pc);
      chk(micro_address, exp_na);
      chk(alternate_address_reg, exp_alt);
   endtask
   always @(posedge clock) begin
      cycle_count++;
      if (cycle_count == 1000) begin
         err_total++;
         summarize();
      end
   end
   initial begin
      {clock, phase1_start, gated_system_clock, phase3_clock, forced_long_format} = '0;
      {condition_met, sequencer_hold, barrel_load_req, phase3_conditional_bit, pend} = '0;
      {word, tf, ff, barrel_shifter, exp_pc, exp_alt, exp_na, bar_val} = '0;
      {err_total, samples_checked, cycle_count} = '0;
      sys_rst = 1'b1;
      clk_en = 1'b1;
      repeat (8) @(posedge clock);
      #1;
      sys_rst = 1'b0;
      chk(micro_program_counter, 14'h0);
      chk(micro_address, 14'h0);
      chk(alternate_address_reg, 14'h0);
      run(16'h0100, 1'b0, 3'h1, 1'b1, 1'b0, 1'b0, 1'b0);
      for (int i = 1; i < 9; i++) run(16'hf000, 1'b0, 3'(i), i[0], 1'b0, 1'b0, 1'b0);
      run(16'hf000, 1'b0, 3'h1, 1'b1, 1'b0, 1'b1, 1'b0);
      run(16'h7ffe, 1'b0, 3'h0, 1'b1, 1'b0, 1'b0, 1'b0);
      run(16'hf000, 1'b0, 3'h1, 1'b1, 1'b0, 1'b0, 1'b0);
      run(16'h8200, 1'b0, 3'h0, 1'b1, 1'b0, 1'b0, 1'b0);
      run(16'hc000, 1'b0, 3'h0, 1'b1, 1'b0, 1'b0, 1'b0);
      run(16'he000, 1'b0, 3'h0, 1'b1, 1'b0, 1'b0, 1'b0);
      run(16'hf000, 1'b1, 3'h0, 1'b1, 1'b0, 1'b0, 1'b0);
      run(16'hf111, 1'b0, 3'h1, 1'b0, 1'b1, 1'b0, 1'b1);
      run(16'hf234, 1'b0, 3'h1, 1'b1, 1'b0, 1'b0, 1'b1);
      run(16'he000, 1'b0, 3'h1, 1'b1, 1'b0, 1'b0, 1'b0);
      run(16'hf000, 1'b0, 3'h1, 1'b1, 1'b0, 1'b0, 1'b0);
      // A blocked short word passes the pending store on to the next one
      run(16'hf0a5, 1'b0, 3'h1, 1'b1, 1'b0, 1'b0, 1'b1);
      run(16'hf000, 1'b0, 3'h1, 1'b0, 1'b1, 1'b0, 1'b0);
      run(16'hf000, 1'b0, 3'h1, 1'b1, 1'b0, 1'b0, 1'b0);
      // Clock enable low: a strobed gated pulse must move nothing
      clk_en = 1'b0;
      gated_system_clock = 1'b1;
      @(posedge clock);
      #1;
      gated_system_clock = 1'b0;
      clk_en = 1'b1;
      chk(micro_program_counter, exp_pc);
      chk(micro_address, exp_na);
      summarize();
   end
endmodule // mps_sequencer_test
`default_nettype wire
